// File: core/rtcw_core.sv
// Oscillator control, trim, alarm, watchdog and square wave of the RTC
//
// Function
// R01: Oscillator runs while oscillator_off is 0, stops when it is 1.
// R02: After re-enable, oscillator becomes active after about one second.
// R03: At power-up, no oscillator within 5 ms sets oscillator_failed_flag.
// R04: Oscillator failure reloads base time; control and trim untouched.
// R05: Software clears oscillator_failed_flag under the time-set hold bit.
// R06: Trim magnitude 0..31 comes from the five low trim bits.
// R07: Trim bit D5 is the sign; 1 speeds up, 0 slows down.
// R08: 64-minute cycle; adjusted second shortened 256 or lengthened 128.
// R09: Magnitude N adjusts the first 2N minutes, one second each.
// R10: Calibration-test bit puts 512 Hz on the interrupt pin.
// R11: Test output frequency ignores the trim register value.
// R12: Software changes the calibration-test bit under the hold bit.
// R13: Alarm match sets alarm_match_flag, interrupt if alarm_irq_enable.
// R14: Field joins match when its mask bit is 0; all ones disables.
// R15: Reading flags clears alarm and watchdog flags and their interrupt.
// R16: New alarm values apply only when the hold bit returns to 0.
// R17: Software keeps the seconds mask bit at 0.
// R18: Watchdog counts down on a 32 Hz tick while oscillator runs.
// R19: Power-up loads watchdog; kick reloads; zero sets timeout flag.
// R20: Timeout bits are written only when watchdog_value_lock is 0.
// R21: Timeout value 0 disables the watchdog completely.
// R22: Square wave 1, 512, 4096 or 32768 Hz; none on backup power.
// R23: Rate select 00,01,10,11 picks 1, 512, 4096, 32768 Hz.
// R24: Calibration output wins over the square wave.
// R25: All ticks come from the oscillator by binary division.
`timescale 1ns/1ps
`default_nettype none
module rtcw_core
    import rtcw_pkg::*;
#(
    parameter int START_CYC = OSC_START_CYC,
    parameter int CHECK_CYC = OSC_CHECK_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Memory bus window
    input wire logic [20:0] addr,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    // Crystal oscillator
    input wire logic osc_in,
    output logic osc_en,
    // Timekeeping counters
    input wire logic [7:0] cur_sec,
    input wire logic [7:0] cur_min,
    input wire logic [7:0] cur_hour,
    input wire logic [7:0] cur_date,
    output logic sec_tick,
    output logic time_reload,
    // Power and interrupt pin
    input wire logic on_backup,
    output logic int_o
);

    typedef struct packed {
        logic hold;
        logic rd_bit;
        logic cal;
        logic oscillator_failed_flag;
        logic af;
        logic watchdog_timeout_flag;
        logic [3:0][7:0] alm_new;
        logic [3:0][7:0] alm;
        logic [7:0] irq;
        logic lock;
        logic [5:0] wd_to;
        logic [5:0] wd_cnt;
        logic [7:0] trim;
        logic osc_prev;
        logic osc_act;
        logic [START_W-1:0] start_cnt;
        logic [CHECK_W-1:0] chk_cnt;
        logic chk_done;
        logic [14:0] div;
        logic [15:0] sec_len;
        logic [5:0] sec_no;
        logic [5:0] min_no;
        logic wr_prev;
        logic rd_prev;
        logic match_prev;
        logic [7:0] dq_out;
        logic dq_oe;
        logic int_q;
        logic sec_tick;
        logic time_reload;
        logic osc_en;
    } rtcw_state_type;

    rtcw_state_type st_r;
    rtcw_state_type st_nxt;

    logic osc_edge;
    logic tick;
    logic wd_tick;
    logic wr_go;
    logic rd_go;
    logic hit;
    logic match;
    logic [3:0] fld_ok;
    logic [3:0][7:0] cur;
    logic [15:0] sec_end;
    logic adj;

    ////////////////////////////////////////////////////////////////////////
    // Decode and divider taps

    assign osc_edge = osc_in & ~st_r.osc_prev;
    assign tick = osc_edge & st_r.osc_act & ~st_r.trim[TR_OFF]; // R18
    assign wd_tick = tick & (st_r.div[9:0] == WDOG_DIV_END); // R25
    assign wr_go = ~ce_b & ~we_b & ~st_r.wr_prev;
    assign rd_go = ~ce_b & ~oe_b & we_b & ~st_r.rd_prev;
    assign hit = (addr >= ADDR_FLAGS) && (addr <= ADDR_TRIM);
    assign cur = {cur_date, cur_hour, cur_min, cur_sec};
    // Per-field alarm compare; a masked field always agrees
    for (genvar gi = 0; gi < 4; gi++)
    begin : g_fld
        assign fld_ok[gi] = st_r.alm[gi][ALM_MASK] ||
            (st_r.alm[gi][6:0] == cur[gi][6:0]); // R14
    end
    assign match = (&fld_ok) && ~(st_r.alm[0][ALM_MASK] &
        st_r.alm[1][ALM_MASK] & st_r.alm[2][ALM_MASK] &
        st_r.alm[3][ALM_MASK]); // R14

    // First second of each of the first 2N minutes is adjusted
    assign adj = (st_r.sec_no == 6'h00) &&
        (st_r.min_no < {st_r.trim[4:0], 1'b0}); // R06 R09
    assign sec_end = !adj ? OSC_PER_SEC :
        st_r.trim[TR_SIGN] ? OSC_PER_SEC - CAL_POS_CYC :
        OSC_PER_SEC + CAL_NEG_CYC; // R07 R08

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sec_tick = 1'b0;
        st_nxt.time_reload = 1'b0;
        st_nxt.osc_prev = osc_in;
        st_nxt.wr_prev = ~ce_b & ~we_b;
        st_nxt.rd_prev = ~ce_b & ~oe_b & we_b;
        st_nxt.osc_en = ~st_r.trim[TR_OFF]; // R01

        // Read port; data is sampled before this cycle's updates
        st_nxt.dq_oe = ~ce_b & ~oe_b & we_b & hit;
        case (addr)
            ADDR_FLAGS:
                st_nxt.dq_out = {st_r.watchdog_timeout_flag, st_r.af, 1'b0, st_r.oscillator_failed_flag,
                    1'b0, st_r.cal, st_r.hold, st_r.rd_bit};
            ADDR_ALM_SEC, ADDR_ALM_SEC + 21'h000001,
            ADDR_ALM_SEC + 21'h000002, ADDR_ALM_DATE:
                st_nxt.dq_out = st_r.alm_new[addr[1:0] - 2'h2];
            ADDR_IRQ:
                st_nxt.dq_out = st_r.irq;
            ADDR_WDOG:
                st_nxt.dq_out = {1'b0, st_r.lock, st_r.wd_to};
            ADDR_TRIM:
                st_nxt.dq_out = st_r.trim;
            default:
                st_nxt.dq_out = 8'h00;
        endcase

        // Clears come first so that a same-cycle event still sets
        if (rd_go && addr == ADDR_FLAGS)
        begin
            st_nxt.af = 1'b0; // R15
            st_nxt.watchdog_timeout_flag = 1'b0; // R15
        end

        if (wr_go)
        begin
            case (addr)
                ADDR_FLAGS:
                begin
                    st_nxt.hold = dq_in[FL_HOLD];
                    st_nxt.rd_bit = dq_in[FL_READ];
                    if (st_r.hold)
                    begin
                        st_nxt.cal = dq_in[FL_CAL];
                        if (!dq_in[FL_OSCILLATOR_FAILED_FLAG])
                            st_nxt.oscillator_failed_flag = 1'b0;
                    end
                    if (st_r.hold && !dq_in[FL_HOLD])
                        st_nxt.alm = st_r.alm_new; // R16
                end
                ADDR_ALM_SEC, ADDR_ALM_SEC + 21'h000001,
                ADDR_ALM_SEC + 21'h000002, ADDR_ALM_DATE:
                    if (st_r.hold)
                        st_nxt.alm_new[addr[1:0] - 2'h2] = dq_in; // R16
                ADDR_IRQ:
                    st_nxt.irq = dq_in;
                ADDR_WDOG:
                begin
                    st_nxt.lock = dq_in[WD_LOCK];
                    if (!dq_in[WD_LOCK])
                        st_nxt.wd_to = dq_in[5:0]; // R20
                    if (dq_in[WD_KICK])
                        st_nxt.wd_cnt = dq_in[WD_LOCK] ? st_r.wd_to :
                            dq_in[5:0]; // R19
                end
                ADDR_TRIM:
                begin
                    st_nxt.trim = dq_in;
                    if (st_r.trim[TR_OFF] && !dq_in[TR_OFF])
                        st_nxt.start_cnt = START_W'(START_CYC); // R02
                end
                default:
                    st_nxt.trim = st_r.trim;
            endcase
        end

        // Startup: no edge counts until the settling time is over
        if (st_r.trim[TR_OFF])
            st_nxt.osc_act = 1'b0; // R01
        else if (st_r.start_cnt != '0)
            st_nxt.start_cnt = st_r.start_cnt - 1'b1; // R02
        else if (osc_edge)
            st_nxt.osc_act = 1'b1;

        // Power-up check window
        if (!st_r.chk_done)
        begin
            st_nxt.chk_cnt = st_r.chk_cnt + 1'b1;
            if (st_r.chk_cnt == CHECK_W'(CHECK_CYC - 1))
            begin
                st_nxt.chk_done = 1'b1;
                if (!st_r.trim[TR_OFF] && !st_r.osc_act && !osc_edge)
                begin
                    st_nxt.oscillator_failed_flag = 1'b1; // R03
                    st_nxt.time_reload = 1'b1; // R04
                end
            end
        end

        // Free divider feeds the test output, the 1, 512 and 4096 Hz square outputs and the watchdog tick
        if (tick)
            st_nxt.div = st_r.div + 1'b1; // R11 R25

        // Trimmed seconds
        if (tick)
        begin
            if (st_r.sec_len >= sec_end - 16'h0001)
            begin
                st_nxt.sec_len = 16'h0000;
                st_nxt.sec_tick = 1'b1; // R08
                if (st_r.sec_no == SEC_LAST)
                begin
                    st_nxt.sec_no = 6'h00;
                    st_nxt.min_no = st_r.min_no + 1'b1; // R08
                end
                else
                    st_nxt.sec_no = st_r.sec_no + 1'b1;
            end
            else
                st_nxt.sec_len = st_r.sec_len + 1'b1;
        end

        // Watchdog; a zero timeout never fires
        if (wd_tick && st_r.wd_to != 6'h00 && !(wr_go && addr == ADDR_WDOG))
        begin
            if (st_r.wd_cnt <= 6'h01)
            begin
                st_nxt.watchdog_timeout_flag = 1'b1; // R19 R21
                st_nxt.wd_cnt = st_r.wd_to;
            end
            else
                st_nxt.wd_cnt = st_r.wd_cnt - 1'b1; // R18
        end

        // Alarm flag on the rising match only
        st_nxt.match_prev = match;
        if (match && !st_r.match_prev)
            st_nxt.af = 1'b1; // R13

        // Pin priority: backup off, then test, square, interrupts
        if (on_backup)
            st_nxt.int_q = 1'b0; // R22
        else if (st_r.cal)
            st_nxt.int_q = st_r.div[DIV_512]; // R10 R24
        else if (st_r.irq[IR_SQUARE_OUT_ENABLE])
        begin
            case (st_r.irq[1:0])
                2'h0: st_nxt.int_q = st_r.div[DIV_1HZ]; // R23
                2'h1: st_nxt.int_q = st_r.div[DIV_512];
                2'h2: st_nxt.int_q = st_r.div[DIV_4K];
                default: st_nxt.int_q = st_r.osc_prev & st_r.osc_act;
            endcase
        end
        else
            st_nxt.int_q = (st_r.irq[IR_WIE] & st_r.watchdog_timeout_flag) |
                (st_r.irq[IR_AIE] & st_r.af); // R13 R19
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.irq <= IRQ_RST;
            st_r.trim <= TRIM_RST;
            st_r.wd_to <= WDOG_TO_RST;
            st_r.wd_cnt <= WDOG_TO_RST; // R19
            st_r.alm <= {4{8'h80}};
            st_r.alm_new <= {4{8'h80}};
        end
        else
            st_r <= st_nxt;
    end

    assign dq_out = st_r.dq_out;
    assign dq_oe = st_r.dq_oe;
    assign osc_en = st_r.osc_en;
    assign sec_tick = st_r.sec_tick;
    assign time_reload = st_r.time_reload;
    assign int_o = st_r.int_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    osc_stop_a: assert property ( // R01
        st_r.trim[TR_OFF] |=> !osc_en)
        else $error("oscillator enabled while switched off");
    osc_settle_a: assert property ( // R02
        $fell(st_r.trim[TR_OFF]) |-> !st_r.osc_act [*8])
        else $error("oscillator active before settling");
    osc_fail_a: assert property ( // R03
        (!st_r.chk_done && st_r.chk_cnt == CHECK_W'(CHECK_CYC - 1) &&
        !st_r.trim[TR_OFF] && !st_r.osc_act && !osc_edge)
        |=> st_r.oscillator_failed_flag && time_reload)
        else $error("oscillator failure not flagged");
    flag_clear_a: assert property ( // R15
        (rd_go && addr == ADDR_FLAGS && !(match && !st_r.match_prev) &&
        !wd_tick) |=> !st_r.af && !st_r.watchdog_timeout_flag)
        else $error("flags survive a flags read");
    wd_fire_a: assert property ( // R19
        (wd_tick && st_r.wd_to != 6'h00 && st_r.wd_cnt == 6'h01 &&
        !(wr_go && addr == ADDR_WDOG))
        |=> st_r.watchdog_timeout_flag && st_r.wd_cnt == $past(st_r.wd_to))
        else $error("watchdog did not time out");
    wd_lock_a: assert property ( // R20
        (wr_go && addr == ADDR_WDOG && dq_in[WD_LOCK])
        |=> $stable(st_r.wd_to))
        else $error("locked timeout was changed");
    wd_off_a: assert property ( // R21
        (st_r.wd_to == 6'h00 && !st_r.watchdog_timeout_flag) |=> !st_r.watchdog_timeout_flag)
        else $error("disabled watchdog raised its flag");
    cal_out_a: assert property ( // R10
        (!on_backup && st_r.cal) |=> int_o == $past(st_r.div[DIV_512]))
        else $error("test output is not the 512 Hz tap");
    backup_quiet_a: assert property ( // R22
        on_backup |=> !int_o)
        else $error("pin driven on backup power");
    alarm_hold_a: assert property ( // R16
        (st_r.hold && !(wr_go && addr == ADDR_FLAGS)) |=> $stable(st_r.alm))
        else $error("alarm applied while held");
endmodule
`default_nettype wire

// File: core/rtcw_pkg.sv
// Constants for the RTC oscillator, trim, alarm and watchdog block
package rtcw_pkg;
    // Register addresses on the memory bus
    localparam logic [20:0] ADDR_FLAGS = 21'h1FFFF0;
    localparam logic [20:0] ADDR_ALM_SEC = 21'h1FFFF2;
    localparam logic [20:0] ADDR_ALM_DATE = 21'h1FFFF5;
    localparam logic [20:0] ADDR_IRQ = 21'h1FFFF6;
    localparam logic [20:0] ADDR_WDOG = 21'h1FFFF7;
    localparam logic [20:0] ADDR_TRIM = 21'h1FFFF8;
    // Field positions
    localparam int FL_READ = 0;
    localparam int FL_HOLD = 1;
    localparam int FL_CAL = 2;
    localparam int FL_OSCILLATOR_FAILED_FLAG = 4;
    localparam int FL_AF = 6;
    localparam int FL_WDF = 7;
    localparam int IR_SQUARE_OUT_ENABLE = 4;
    localparam int IR_AIE = 6;
    localparam int IR_WIE = 7;
    localparam int WD_KICK = 7;
    localparam int WD_LOCK = 6;
    localparam int TR_OFF = 7;
    localparam int TR_SIGN = 5;
    localparam int ALM_MASK = 7;
    // Values after reset
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [5:0] WDOG_TO_RST = 6'h00;
    // Times and cycle counts
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_START_NS = 1_000_000_000;
    localparam int OSC_CHECK_NS = 5_000_000;
    localparam int OSC_START_CYC = OSC_START_NS / CLK_PERIOD_NS;
    localparam int OSC_CHECK_CYC = OSC_CHECK_NS / CLK_PERIOD_NS;
    localparam int START_W = 24;
    localparam int CHECK_W = 16;
    // Oscillator division and trim
    localparam logic [15:0] OSC_PER_SEC = 16'h8000;
    localparam logic [15:0] CAL_POS_CYC = 16'h0100;
    localparam logic [15:0] CAL_NEG_CYC = 16'h0080;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [9:0] WDOG_DIV_END = 10'h3FF;
    localparam int DIV_1HZ = 14;
    localparam int DIV_512 = 5;
    localparam int DIV_4K = 2;
endpackage

// File: verif/rtcw_host.sv
// Host bus master model for the RTC register window
`timescale 1ns/1ps
`default_nettype none
module rtcw_host (
    // Clock and read return
    input wire logic clk,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    // Memory bus drive
    output logic [20:0] addr,
    output logic ce_b,
    output logic oe_b,
    output logic we_b,
    output logic [7:0] dq_in
);
    initial
    begin
        addr = 21'h000000;
        ce_b = 1'b1;
        oe_b = 1'b1;
        we_b = 1'b1;
        dq_in = 8'hA5;
    end
    task automatic wr(input logic [20:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        dq_in = d;
        ce_b = 1'b0;
        we_b = 1'b0;
        @(posedge clk);
        #1;
        ce_b = 1'b1;
        we_b = 1'b1;
        // Released bus must not keep showing the written byte
        dq_in = ~d;
    endtask
    task automatic rd(input logic [20:0] a, output logic [7:0] d,
                      output logic oe);
        @(posedge clk);
        #1;
        addr = a;
        ce_b = 1'b0;
        oe_b = 1'b0;
        @(posedge clk);
        #1;
        d = dq_out;
        oe = dq_oe;
        ce_b = 1'b1;
        oe_b = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the RTC timekeeping support block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rtcw_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic osc_in = 1'b0;
    logic osc_run = 1'b0;
    logic on_backup = 1'b0;
    logic [7:0] cv [4] = '{default: 8'h00};
    logic [20:0] addr;
    logic ce_b, oe_b, we_b, dq_oe, osc_en, sec_tick, time_reload, int_o;
    logic [7:0] dq_in, dq_out, d;
    logic [7:0] w [4];
    logic oe;
    logic [31:0] seed = 32;
    int mismatches = 0;
    int n_tests = 0;
    int reloads = 0;
    int n;
    localparam int SETTLE = 20;
    int cyc = 0;
    int t0 = 0;
    int sec_at = 0;
    always #50 clk = ~clk;
    // Fast crystal stand-in keeps the run short
    always @(posedge clk)
        if (osc_run)
            osc_in <= #1 ~osc_in;
    always @(posedge clk)
        if (time_reload === 1'b1)
            reloads <= reloads + 1;
    always @(posedge clk)
        cyc <= cyc + 1;
    // First trimmed second, in clocks since the start of the run
    always @(posedge clk)
        if (sec_tick === 1'b1 && sec_at == 0)
            sec_at <= cyc;
    rtcw_core #(.START_CYC(SETTLE), .CHECK_CYC(40)) dut (
        .clk(clk), .rst_b(rst_b), .addr(addr), .ce_b(ce_b), .oe_b(oe_b),
        .we_b(we_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .osc_in(osc_in), .osc_en(osc_en), .cur_sec(cv[0]),
        .cur_min(cv[1]), .cur_hour(cv[2]), .cur_date(cv[3]),
        .sec_tick(sec_tick), .time_reload(time_reload),
        .on_backup(on_backup), .int_o(int_o));
    rtcw_host host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .addr(addr), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .dq_in(dq_in));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int half_clk(input logic [1:0] r);
        case (r)
            2'd0: return 2 << DIV_1HZ;
            2'd1: return 2 << DIV_512;
            2'd2: return 2 << DIV_4K;
            default: return 1;
        endcase
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rdc(input logic [20:0] a, input logic [7:0] e);
        host.rd(a, d, oe);
        chk({oe, d}, {1'b1, e});
    endtask
    task automatic wait_chg(input int lim, output int k);
        logic v;
        v = int_o;
        k = 0;
        while (int_o === v && k < lim)
        begin
            tick(1);
            k++;
        end
    endtask
    task automatic half(input int lim, output int k);
        wait_chg(lim, k);
        wait_chg(lim, k);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #9_000_000;
        mismatches++;
        conclude();
    end
    initial
    begin
        tick(20);
        rst_b = 1'b1;
        // Crystal held still through the power-up check
        tick(60);
        chk(reloads, 1);
        rdc(ADDR_FLAGS, 8'h10);
        rdc(ADDR_TRIM, 8'h00);
        chk(osc_en, 1'b1);
        host.wr(ADDR_FLAGS, 8'h02);
        host.wr(ADDR_FLAGS, 8'h02);
        host.wr(ADDR_FLAGS, 8'h00);
        rdc(ADDR_FLAGS, 8'h00);
        rdc(ADDR_WDOG, 8'h00);
        rdc(ADDR_ALM_SEC, 8'h80);
        rdc(ADDR_ALM_SEC - 21'h1, 8'h00);
        host.rd(21'h000100, d, oe);
        chk(oe, 1'b0);
        // No tick may count before the restart below
        host.wr(ADDR_TRIM, 8'h80);
        osc_run = 1'b1;
        tick(2);
        chk(osc_en, 1'b0);
        host.wr(ADDR_TRIM, 8'h00);
        t0 = cyc;
        tick(2);
        chk(osc_en, 1'b1);
        // Alarm write without hold must be dropped
        host.wr(ADDR_ALM_SEC, 8'h25);
        host.wr(ADDR_IRQ, 8'h40);
        cv[0] = 8'h25;
        tick(4);
        chk(int_o, 1'b0);
        for (int f = 0; f < 4; f++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                seed = lfsr(seed);
                w[k] = {2'b00, seed[5:0]} | 8'h01;
                cv[k] = w[k] ^ 8'h01;
            end
            host.wr(ADDR_FLAGS, 8'h02);
            for (int k = 0; k < 4; k++)
                host.wr(ADDR_ALM_SEC + 21'(k),
                        (k == 0 || k == f) ? w[k] : 8'h80);
            host.wr(ADDR_FLAGS, 8'h00);
            rdc(ADDR_FLAGS, 8'h00);
            cv[0] = w[0];
            cv[f] = w[f];
            tick(4);
            chk(int_o, 1'b1);
            rdc(ADDR_FLAGS, 8'h40);
            tick(1);
            chk(int_o, 1'b0);
        end
        host.wr(ADDR_IRQ, 8'h13);
        host.wr(ADDR_FLAGS, 8'h02);
        host.wr(ADDR_FLAGS, 8'h06);
        host.wr(ADDR_FLAGS, 8'h04);
        half(500, n);
        chk(n, half_clk(2'd1));
        host.wr(ADDR_TRIM, 8'h3F);
        half(500, n);
        chk(n, half_clk(2'd1));
        // Sign stays positive so the first second is shortened
        host.wr(ADDR_TRIM, 8'h21);
        host.wr(ADDR_FLAGS, 8'h02);
        host.wr(ADDR_FLAGS, 8'h02);
        host.wr(ADDR_FLAGS, 8'h00);
        for (int r = 3; r >= 0; r--)
        begin
            host.wr(ADDR_IRQ, 8'h10 | 8'(r));
            tick(2);
            half(70000, n);
            chk(n, half_clk(2'(r)));
        end
        host.wr(ADDR_IRQ, 8'h13);
        on_backup = 1'b1;
        tick(3);
        wait_chg(50, n);
        chk({int_o, 8'(n)}, {1'b0, 8'd50});
        on_backup = 1'b0;
        host.wr(ADDR_IRQ, 8'h80);
        host.wr(ADDR_WDOG, 8'h81);
        n = 0;
        while (int_o !== 1'b1 && n < 4200)
        begin
            tick(1);
            n++;
        end
        chk(int_o, 1'b1);
        rdc(ADDR_FLAGS, 8'h80);
        tick(1);
        chk(int_o, 1'b0);
        host.wr(ADDR_WDOG, 8'h45);
        host.rd(ADDR_WDOG, d, oe);
        chk(d[5:0], 6'h01);
        host.wr(ADDR_WDOG, 8'h80);
        host.rd(ADDR_FLAGS, d, oe);
        tick(5000);
        chk(int_o, 1'b0);
        rdc(ADDR_FLAGS, 8'h00);
        // Crystal rises every second clock; 1..2 clocks to go active
        n = sec_at - t0 - SETTLE - 2 * int'(OSC_PER_SEC - CAL_POS_CYC);
        chk(32'(n == 1 || n == 2), 32'h1);
        conclude();
    end
endmodule
`default_nettype wire
